// ===== src/wit_baud_gen.sv
// main-clock divider producing the nominal 32.768 kHz watch clock tick
`include "wit_defs.svh"

module wit_baud_gen (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       enable,
  input  wire logic [1:0] src_sel,
  input  wire logic [7:0] cmp,
  output logic            brg_tick
);

  logic [2:0] div_q;
  logic [8:0] cnt_q;
  logic [8:0] half_n;
  logic [8:0] top;
  logic       src_tick;

  // source is fx / 2^m taken from the 3-bit prescaler
  always_comb begin
    case (src_sel)
      2'd0:    src_tick = 1'b1;
      2'd1:    src_tick = div_q[0];
      2'd2:    src_tick = &div_q[1:0];
      default: src_tick = &div_q;
    endcase
  end

  // a stored zero means 256; period is 2N source ticks
  assign half_n = (cmp == 8'h00) ? `WIT_CMP_ZERO_N : {1'b0, cmp};
  assign top    = 9'({half_n, 1'b0} - 10'd1);

  // counters held clear while disabled, so no stray tick leaks out
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_q    <= 3'h0;
      cnt_q    <= 9'h000;
      brg_tick <= 1'b0;
    end else if (!enable) begin
      div_q    <= 3'h0;
      cnt_q    <= 9'h000;
      brg_tick <= 1'b0;
    end else begin
      div_q    <= div_q + 3'd1;
      brg_tick <= src_tick && (cnt_q == top);
      if (src_tick) begin
        cnt_q <= (cnt_q == top) ? 9'h000 : cnt_q + 9'd1;
      end
    end
  end

  // helper: cycles since the previous tick
  logic [12:0] gap_q;
  logic        seen_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gap_q  <= 13'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= brg_tick ? 13'd1 : gap_q + 13'd1;
      seen_q <= enable && (seen_q || brg_tick);
    end
  end

  brg_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !enable |=> !brg_tick) else $error("watch clock tick while prescaler off");

  brg_period_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (brg_tick && seen_q && enable)
      |-> (gap_q == (13'({half_n, 1'b0}) << src_sel)))
    else $error("watch clock period differs from 2N times 2^m");

endmodule // wit_baud_gen

// ===== src/wit_defs.svh
// register map, field positions and reset values of the watch/interval timer
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH

// ----------------------------------------------------------------------------
// register map (byte addresses, one byte each)
// ----------------------------------------------------------------------------
`define WIT_ADDR_W        32
`define WIT_DATA_W        8
`define WIT_OFS_MODE      32'hFFFFF680
`define WIT_OFS_PSMODE    32'hFFFFF684
`define WIT_OFS_CMP       32'hFFFFF688
`define WIT_OFS_STATUS    32'hFFFFF68C

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define WIT_RST_MODE      8'h00
`define WIT_RST_PSMODE    8'h00
`define WIT_RST_CMP       8'h00

// ----------------------------------------------------------------------------
// watch mode control fields
// ----------------------------------------------------------------------------
`define WIT_MODE_RUN      0
`define WIT_MODE_CNT      1
`define WIT_MODE_WP_LO    2
`define WIT_MODE_WP_HI    3
`define WIT_MODE_IV_LO    4
`define WIT_MODE_IV_HI    6
`define WIT_MODE_SRC      7

// ----------------------------------------------------------------------------
// prescaler mode fields and single-bit write encoding
// ----------------------------------------------------------------------------
`define WIT_PS_SEL_LO     0
`define WIT_PS_SEL_HI     1
`define WIT_PS_EN         7
`define WIT_BIT_IDX_HI    2
`define WIT_BIT_VAL       3

// ----------------------------------------------------------------------------
// divider figures
// ----------------------------------------------------------------------------
`define WIT_CMP_ZERO_N    9'd256
`define WIT_IV_BASE       12'h010
`define WIT_SLOW_BITS     9

`endif

// ===== src/wit_pkg.sv
// types shared by the watch/interval timer modules
package wit_pkg;

  // operating phase, gray coded along idle -> interval -> watch
  typedef enum logic [1:0] {
    WIT_IDLE     = 2'b00,
    WIT_INTERVAL = 2'b01,
    WIT_WATCH    = 2'b11
  } wit_state_t;

  typedef logic [7:0] wit_byte_t;

endpackage : wit_pkg

// ===== src/wit_top.sv
// watch timer with interval timer, register port and interrupt pulses
//
// Contract
// - Prescaler mode register resets to zero; byte and single-bit read/write.
// - Prescaler enable set delivers the divided main clock; clear stops it.
// - Compare register is 8 bits, byte access only, resets to zero.
// - Divided watch clock is source over 2N; stored zero means N=256.
// - Source select m picks main clock over 2^m.
// - Operation mode register is 8 bits, resets zero, byte and bit access.
// - Mode 6:4 choose interval 2^4..2^11; bit 7 picks subclock or divider.
// - Mode 3:2 choose watch period 2^14, 2^13, 2^5 or 2^4.
// - Mode bit 1 runs the 5-bit counter; clear stops and clears it.
// - Mode bit 0 clear stops and clears prescaler and counter; set enables.
// - Watch counting starts only when mode bits 1 and 0 are both set.
// - Clearing bit 1 alone clears only the counter; interval keeps running.
// - A 3-bit prescaler makes main clock over 2, 4 and 8.
// - Watch counter counts the watch clock or watch clock/2^9 per period.
//
// The strobed register port was left to the implementer.
`include "wit_defs.svh"

module wit_top (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic                   sub_clk_pin,
  input  wire logic [`WIT_ADDR_W-1:0] reg_addr,
  input  wire logic [`WIT_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_bit_wr,
  input  wire logic                   reg_rd,
  output logic [`WIT_DATA_W-1:0]      reg_rdata_q,
  output logic                        watch_irq,
  output logic                        interval_irq_q
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  wit_pkg::wit_byte_t    mode_q;
  wit_pkg::wit_byte_t    psmode_q;
  wit_pkg::wit_byte_t    cmp_q;
  wit_pkg::wit_state_t   state_q;
  wit_pkg::wit_state_t   state_d;
  logic [10:0]           pre_q;
  logic [10:0]           iv_mask;
  logic [4:0]            watch_count;
  logic [2:0]            bit_idx;
  logic                  bit_val;
  logic                  sel_mode;
  logic                  sel_psmode;
  logic                  sel_cmp;
  logic                  sel_status;
  logic                  brg_tick;
  logic                  wclk_tick;
  logic                  slow_tick;
  logic                  iv_wrap;
  logic                  run_en;
  logic                  sub_s1_q;
  logic                  sub_s2_q;
  logic                  sub_s3_q;
  logic                  sub_lvl_q;
  logic                  sub_rise;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // full-address compare, nothing aliases across the map
  always_comb begin
    sel_mode   = 1'b0;
    sel_psmode = 1'b0;
    sel_cmp    = 1'b0;
    sel_status = 1'b0;
    if (reg_addr == `WIT_OFS_MODE) begin
      sel_mode = 1'b1;
    end else if (reg_addr == `WIT_OFS_PSMODE) begin
      sel_psmode = 1'b1;
    end else if (reg_addr == `WIT_OFS_CMP) begin
      sel_cmp = 1'b1;
    end else if (reg_addr == `WIT_OFS_STATUS) begin
      sel_status = 1'b1;
    end
  end

  // single-bit write carries index and value in the low data bits
  assign bit_idx = reg_wdata[`WIT_BIT_IDX_HI:0];
  assign bit_val = reg_wdata[`WIT_BIT_VAL];

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  // operation mode register, byte or bit writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= `WIT_RST_MODE;
    end else if (reg_wr && sel_mode) begin
      mode_q <= reg_wdata;
    end else if (reg_bit_wr && sel_mode) begin
      mode_q[bit_idx] <= bit_val;
    end
  end

  // prescaler mode register, byte or bit writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      psmode_q <= `WIT_RST_PSMODE;
    end else if (reg_wr && sel_psmode) begin
      psmode_q <= reg_wdata;
    end else if (reg_bit_wr && sel_psmode) begin
      psmode_q[bit_idx] <= bit_val;
    end
  end

  // compare register takes whole bytes only; bit writes are dropped
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_q <= `WIT_RST_CMP;
    end else if (reg_wr && sel_cmp) begin
      cmp_q <= reg_wdata;
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      if (sel_mode) begin
        reg_rdata_q <= mode_q;
      end else if (sel_psmode) begin
        reg_rdata_q <= psmode_q;
      end else if (sel_cmp) begin
        reg_rdata_q <= cmp_q;
      end else if (sel_status) begin
        reg_rdata_q <= {1'b0, state_q, watch_count};
      end else begin
        reg_rdata_q <= 8'h00;
      end
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // subclock pin synchroniser
  // --------------------------------------------------------------------------
  // three stages; a level is accepted once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sub_s1_q  <= 1'b0;
      sub_s2_q  <= 1'b0;
      sub_s3_q  <= 1'b0;
      sub_lvl_q <= 1'b0;
    end else begin
      sub_s1_q <= sub_clk_pin;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
      if (sub_s2_q == sub_s3_q) begin
        sub_lvl_q <= sub_s3_q;
      end
    end
  end

  // the subclock must stay well below ref_clk / 4 for clean edges
  assign sub_rise = (sub_s2_q == sub_s3_q) && sub_s3_q && !sub_lvl_q;

  // --------------------------------------------------------------------------
  // main clock divider
  // --------------------------------------------------------------------------
  wit_baud_gen u_baud (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .enable   (psmode_q[`WIT_PS_EN]),
    .src_sel  (psmode_q[`WIT_PS_SEL_HI:`WIT_PS_SEL_LO]),
    .cmp      (cmp_q),
    .brg_tick (brg_tick)
  );

  // --------------------------------------------------------------------------
  // operating phase
  // --------------------------------------------------------------------------
  // phase follows the two run bits directly
  always_comb begin
    case ({mode_q[`WIT_MODE_CNT], mode_q[`WIT_MODE_RUN]})
      2'b01:   state_d = wit_pkg::WIT_INTERVAL;
      2'b11:   state_d = wit_pkg::WIT_WATCH;
      default: state_d = wit_pkg::WIT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= wit_pkg::WIT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // watch clock and 11-bit prescaler
  // --------------------------------------------------------------------------
  assign run_en = (state_q != wit_pkg::WIT_IDLE);

  // source bit picks divided main clock or subclock
  assign wclk_tick = run_en && (mode_q[`WIT_MODE_SRC] ? brg_tick : sub_rise);

  // prescaler runs in both active phases, so watch adjust leaves it alone
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 11'h000;
    end else if (!run_en) begin
      pre_q <= 11'h000;
    end else if (wclk_tick) begin
      pre_q <= pre_q + 11'd1;
    end
  end

  // interval of 2^(4+k) watch clock cycles
  assign iv_mask = 11'((`WIT_IV_BASE << mode_q[`WIT_MODE_IV_HI:`WIT_MODE_IV_LO]) - 12'h001);
  assign iv_wrap = ((pre_q & iv_mask) == iv_mask);

  // watch clock / 2^9 tap feeding the watch counter on long periods
  assign slow_tick = wclk_tick && (&pre_q[`WIT_SLOW_BITS-1:0]);

  // interval interrupt as a one-cycle pulse
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      interval_irq_q <= 1'b0;
    end else begin
      interval_irq_q <= wclk_tick && iv_wrap;
    end
  end

  // --------------------------------------------------------------------------
  // watch counter
  // --------------------------------------------------------------------------
  wit_watch_cnt u_watch (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .run        (state_q == wit_pkg::WIT_WATCH),
    .wclk_tick  (wclk_tick),
    .slow_tick  (slow_tick),
    .period_sel (mode_q[`WIT_MODE_WP_HI:`WIT_MODE_WP_LO]),
    .count      (watch_count),
    .watch_irq  (watch_irq)
  );

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  // a read strobe followed by its data in the next cycle
  sequence mode_read_s;
    reg_rd && sel_mode && !reg_wr && !reg_bit_wr;
  endsequence

  mode_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode_read_s |=> (reg_rdata_q == $past(mode_q)))
    else $error("mode register read back wrong");

  ps_bitwr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_bit_wr && sel_psmode) |=> (psmode_q[$past(bit_idx)] == $past(bit_val)))
    else $error("prescaler mode bit write lost");

  cmp_bitwr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_bit_wr && sel_cmp) |=> $stable(cmp_q))
    else $error("compare register changed by bit write");

  // byte writes land whole at the strobe edge
  ps_bytewr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && sel_psmode) |=> (psmode_q == $past(reg_wdata)))
    else $error("prescaler mode byte write lost");

  cmp_bytewr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && sel_cmp) |=> (cmp_q == $past(reg_wdata)))
    else $error("compare register byte write lost");

  mode_bytewr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_wr && sel_mode) |=> (mode_q == $past(reg_wdata)))
    else $error("mode register byte write lost");

  // bit writes set just the indexed bit, so run bits can flip alone
  mode_bitwr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reg_bit_wr && sel_mode) |=> (mode_q[$past(bit_idx)] == $past(bit_val)))
    else $error("mode register bit write lost");

  stop_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_q == wit_pkg::WIT_IDLE) |=> (pre_q == 11'h000) && (watch_count == 5'h00))
    else $error("prescaler or counter not cleared while stopped");

  start_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(mode_q[`WIT_MODE_CNT] && mode_q[`WIT_MODE_RUN]) ##1 1 |=> (watch_count == 5'h00))
    else $error("watch counter moved without both run bits");

  adjust_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_q == wit_pkg::WIT_INTERVAL && wclk_tick) |=> (pre_q == $past(pre_q) + 11'd1))
    else $error("interval prescaler disturbed by watch adjust");

  src_pick_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (run_en && !mode_q[`WIT_MODE_SRC] && !sub_rise) |-> !wclk_tick)
    else $error("watch clock tick without subclock edge");

  iv_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    interval_irq_q |=> !interval_irq_q)
    else $error("interval interrupt longer than one cycle");

  iv_cause_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    interval_irq_q |-> $past(wclk_tick) && ($past(pre_q & iv_mask) == $past(iv_mask)))
    else $error("interval interrupt at wrong prescaler count");

  wt_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    watch_irq |=> !watch_irq)
    else $error("watch interrupt longer than one cycle");

  // --------------------------------------------------------------------------
  // silent phases
  // --------------------------------------------------------------------------
  // from the second cycle outside the watch phase no watch pulse may appear; one raised in the last watch cycle still can
  wt_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_q != wit_pkg::WIT_WATCH) |=> !watch_irq)
    else $error("watch interrupt outside watch phase");

  iv_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_q == wit_pkg::WIT_IDLE) |=> !interval_irq_q)
    else $error("interval interrupt while stopped");

  src_main_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (run_en && mode_q[`WIT_MODE_SRC] && !brg_tick) |-> !wclk_tick)
    else $error("watch clock tick without divider tick");

  // watch adjust: leaving the watch phase while the interval phase goes on
  sequence adjust_s;
    (state_q == wit_pkg::WIT_WATCH) ##1 (state_q == wit_pkg::WIT_INTERVAL);
  endsequence

  adjust_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    adjust_s |=> (watch_count == 5'h00) && !watch_irq)
    else $error("watch counter kept its count after adjust");

endmodule // wit_top

// ===== src/wit_watch_cnt.sv
// 5-bit watch counter producing the watch interrupt pulse
module wit_watch_cnt (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic       wclk_tick,
  input  wire logic       slow_tick,
  input  wire logic [1:0] period_sel,
  output logic [4:0]      count,
  output logic            watch_irq
);

  logic step;
  logic wrap;

  // long periods count watch clock / 2^9, short ones every watch clock tick
  assign step = period_sel[1] ? wclk_tick : slow_tick;
  assign wrap = period_sel[0] ? &count[3:0] : &count;

  // counter cleared whenever not running
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count     <= 5'h00;
      watch_irq <= 1'b0;
    end else if (!run) begin
      count     <= 5'h00;
      watch_irq <= 1'b0;
    end else begin
      watch_irq <= step && wrap;
      if (step) begin
        count <= count + 5'd1;
      end
    end
  end

  cnt_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !run |=> (count == 5'h00) && !watch_irq)
    else $error("watch counter not cleared when stopped");

endmodule // wit_watch_cnt

// ===== tb/watch_interval_timer_bench.sv
// self-checking bench for the watch/interval timer: registers, dividers, interrupts
`include "wit_defs.svh"

module watch_interval_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------------
  // stimulus signals and design hookup
  // --------------------------------------------------------------------------
  logic                   ref_clk = 1'b0;
  logic                   rstn;
  logic                   sub_clk_pin = 1'b0;
  logic [`WIT_ADDR_W-1:0] reg_addr;
  logic [`WIT_DATA_W-1:0] reg_wdata;
  logic                   reg_wr;
  logic                   reg_bit_wr;
  logic                   reg_rd;
  logic [`WIT_DATA_W-1:0] reg_rdata_q;
  logic                   watch_irq;
  logic                   interval_irq_q;
  logic [4:0]             sub_div_q = 5'h00;
  int                     num_errors;
  int                     n_compared;
  int                     n;
  int                     k;

  wit_top dut (
    .ref_clk        (ref_clk),
    .rstn           (rstn),
    .sub_clk_pin    (sub_clk_pin),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_bit_wr     (reg_bit_wr),
    .reg_rd         (reg_rd),
    .reg_rdata_q    (reg_rdata_q),
    .watch_irq      (watch_irq),
    .interval_irq_q (interval_irq_q)
  );

  // 100 MHz main clock
  always #5 ref_clk = ~ref_clk;

  // subclock stand-in: 40 main cycles per period, edges on the main clock
  always @(posedge ref_clk) begin
    if (sub_div_q == 5'h13) begin
      sub_div_q   <= 5'h00;
      sub_clk_pin <= ~sub_clk_pin;
    end else begin
      sub_div_q <= sub_div_q + 5'h01;
    end
  end

  // --------------------------------------------------------------------------
  // bus tasks and checks
  // --------------------------------------------------------------------------
  // compare and count; case inequality so unknowns never match
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // one-cycle write strobe; released at the edge that takes it
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic bit_mode);
    @(posedge ref_clk);
    reg_addr   <= a;
    reg_wdata  <= d;
    reg_wr     <= ~bit_mode;
    reg_bit_wr <= bit_mode;
    @(posedge ref_clk);
    reg_wr     <= 1'b0;
    reg_bit_wr <= 1'b0;
  endtask

  // single-bit write: index in [2:0], value in [3]
  task automatic bit_wr(input logic [31:0] a, input logic [2:0] idx, input logic v);
    wr(a, {4'h0, v, idx}, 1'b1);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, exp, "read data");
  endtask

  // cycles until the next pulse; a hang ends the run
  task automatic wait_irq(input logic w, input int bound, output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end while (((w ? watch_irq : interval_irq_q) !== 1'b1) && cnt < bound);
    if ((w ? watch_irq : interval_irq_q) !== 1'b1) begin
      num_errors++;
      $display("ERROR at %0t: interrupt pulse never came", $time);
      complete_run();
    end
  endtask

  // spacing of two pulses; the first may come at any phase
  task automatic gap(input logic w, input int exp);
    int cnt;
    wait_irq(w, 2 * exp + 100, cnt);
    wait_irq(w, exp + 100, cnt);
    check(cnt, exp, "interrupt spacing");
  endtask

  // no pulse at all for a number of cycles
  task automatic quiet(input logic w, input int cycles);
    repeat (cycles) begin
      @(posedge ref_clk);
      #1;
      check(w ? watch_irq : interval_irq_q, 1'b0, "unexpected interrupt");
    end
  endtask

  // drop both run bits alone, program divider with its enable low, then
  // change mode fields while stopped and only then start
  task automatic setup(input logic [7:0] ps, input logic [7:0] cmp, input logic [7:0] mode);
    bit_wr(`WIT_OFS_MODE, 3'h1, 1'b0);
    bit_wr(`WIT_OFS_MODE, 3'h0, 1'b0);
    wr(`WIT_OFS_PSMODE, ps & 8'h7F, 1'b0);
    wr(`WIT_OFS_CMP, cmp, 1'b0);
    wr(`WIT_OFS_PSMODE, ps, 1'b0);
    wr(`WIT_OFS_MODE, mode & 8'hFC, 1'b0);
    wr(`WIT_OFS_MODE, mode, 1'b0);
  endtask

  // counts, verdict and end of run
  task automatic complete_run();
    $display("compared %0d values, %0d mismatches", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    rstn        = 1'b0;
    reg_addr    = 32'h00000000;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_bit_wr  = 1'b0;
    reg_rd      = 1'b0;
    num_errors  = 0;
    n_compared  = 0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;

    // reset values, unmapped place reads zero
    rd(`WIT_OFS_MODE, 8'h00);
    rd(`WIT_OFS_PSMODE, 8'h00);
    rd(`WIT_OFS_CMP, 8'h00);
    rd(32'hFFFFF690, 8'h00);
    rd(`WIT_OFS_STATUS, 8'h00);
    $display("test reset values done");

    // byte and single-bit access; bit 4 changed while stopped
    wr(`WIT_OFS_MODE, 8'hF0, 1'b0);
    rd(`WIT_OFS_MODE, 8'hF0);
    bit_wr(`WIT_OFS_MODE, 3'h4, 1'b0);
    bit_wr(`WIT_OFS_MODE, 3'h0, 1'b1);
    rd(`WIT_OFS_MODE, 8'hE1);
    bit_wr(`WIT_OFS_MODE, 3'h0, 1'b0);
    rd(`WIT_OFS_MODE, 8'hE0);
    wr(`WIT_OFS_CMP, 8'h3D, 1'b0);
    bit_wr(`WIT_OFS_CMP, 3'h0, 1'b0);
    wr(32'hFFFFF690, 8'h55, 1'b0);
    rd(`WIT_OFS_CMP, 8'h3D);
    wr(`WIT_OFS_PSMODE, 8'h03, 1'b0);
    bit_wr(`WIT_OFS_PSMODE, 3'h0, 1'b0);
    bit_wr(`WIT_OFS_PSMODE, 3'h7, 1'b1);
    rd(`WIT_OFS_PSMODE, 8'h82);
    $display("test register access done");

    // every interval select, fastest divider: 2 cycles per watch clock
    for (k = 0; k < 8; k++) begin
      setup(8'h80, 8'h01, {1'b1, k[2:0], 4'h1});
      gap(1'b0, 32 << k);
    end
    $display("test interval selects done");

    // every source division with N of 3, then stored zero as 256
    for (k = 0; k < 4; k++) begin
      setup({6'h20, k[1:0]}, 8'h03, 8'h81);
      gap(1'b0, 96 << k);
    end
    setup(8'h80, 8'h00, 8'h81);
    gap(1'b0, 8192);
    $display("test divider settings done");

    // divider disabled gives no watch clock until its enable is set
    setup(8'h00, 8'h01, 8'h81);
    quiet(1'b0, 300);
    setup(8'h80, 8'h01, 8'h81);
    gap(1'b0, 32);
    // operation enable low keeps everything silent
    setup(8'h80, 8'h01, 8'h8E);
    quiet(1'b0, 300);
    quiet(1'b1, 100);
    // subclock as watch clock: 40 cycles per tick
    setup(8'h80, 8'h01, 8'h01);
    gap(1'b0, 640);
    $display("test clock gating and source done");

    // short watch periods count the watch clock directly
    setup(8'h80, 8'h01, 8'h8F);
    gap(1'b1, 32);
    setup(8'h80, 8'h01, 8'h8B);
    gap(1'b1, 64);
    // long periods: first pulse from a clean start, one slow tick of slack
    for (k = 0; k < 2; k++) begin
      setup(8'h80, 8'h01, (k == 0) ? 8'h87 : 8'h83);
      wait_irq(1'b1, (16384 << k) + 40, n);
      check(n > (16384 << k) - 1100, 1'b1, "first watch pulse too early");
    end
    $display("test watch periods done");

    // counter off while the interval runs, then start and adjust
    setup(8'h80, 8'h01, 8'h8D);
    quiet(1'b1, 200);
    rd(`WIT_OFS_STATUS, 8'h20);
    bit_wr(`WIT_OFS_MODE, 3'h1, 1'b1);
    wait_irq(1'b1, 40, n);
    check(n >= 24, 1'b1, "watch start too early");
    wait_irq(1'b0, 100, n);
    bit_wr(`WIT_OFS_MODE, 3'h1, 1'b0);
    wait_irq(1'b0, 100, n);
    check(n, 30, "interval phase after adjust");
    quiet(1'b1, 100);
    $display("test watch adjust done");

    complete_run();
  end

endmodule // watch_interval_timer_bench
